// file: iosr_pkg.sv
// constants and types shared by the io sample reporter
package iosr_pkg;
   localparam int          IOSR_LINES    = 13;
   localparam int          IOSR_ADC_CH   = 4;
   localparam int          IOSR_ADC_W    = 10;
   localparam int          IOSR_CFG_W    = 4;
   localparam int          IOSR_MASK_W   = 16;
   localparam int          IOSR_AMASK_W  = 8;
   localparam int          IOSR_MAX_B    = 16;
   localparam int          IOSR_IDX_W    = 4;
   localparam int          IOSR_HDR_B    = 4;
   localparam int          IOSR_SUP_BIT  = 7;
   localparam int          IOSR_TIME_W   = 16;
   localparam logic [7:0]  SAMPLE_SETS   = 8'h01;
   localparam logic [15:0] UNUSED_LINES  = 16'he300;
   localparam logic [9:0]  ADC_FULL      = 10'h3ff;
   localparam logic [3:0]  CFG_DIN_PLAIN = 4'h0;
   localparam logic [3:0]  CFG_ANALOG    = 4'h2;
   localparam logic [3:0]  CFG_DIN_MON   = 4'h3;
   localparam logic [3:0]  CFG_DOUT_LO   = 4'h4;
   localparam logic [3:0]  CFG_DOUT_HI   = 4'h5;
   localparam logic [63:0] COORD_ADDR    = 64'h0;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          MS_IN_NS      = 1000000;
   localparam int          MS_CYCLES     = MS_IN_NS / CLK_PERIOD_NS;

   typedef logic [IOSR_LINES-1:0][IOSR_CFG_W-1:0] iosr_cfg_t;

   typedef enum logic {IOSR_TO_SERIAL, IOSR_TO_AIR} iosr_route_e;

   typedef struct packed {
      logic [IOSR_MASK_W-1:0]                   dmask;
      logic [IOSR_AMASK_W-1:0]                  amask;
      logic [IOSR_MASK_W-1:0]                   dstate;
      logic [IOSR_ADC_CH-1:0][IOSR_ADC_W-1:0]   adc;
      logic [IOSR_ADC_W-1:0]                    supply;
   } iosr_snap_s;

   typedef struct packed {
      iosr_route_e  route;
      logic         toCoord;
      logic         framed;
      logic [63:0]  addr;
   } iosr_dest_s;
endpackage

// file: iosr_rec_builder.sv
// lays a sample snapshot out as record bytes, one byte picked by index
`timescale 1ns/100ps
module iosr_rec_builder import iosr_pkg::*; (
   // snapshot and byte select
   input  iosr_snap_s            snap,
   input  wire logic [IOSR_IDX_W-1:0] idx,
   // selected byte
   output logic [7:0]            byteOut,
   output logic                  lastOut,
   output logic                  fieldEnd
);
   logic [7:0] recBuf  [IOSR_MAX_B];
   logic       endFlag [IOSR_MAX_B];
   int         n;

   function automatic logic [15:0] adcWord(input logic [IOSR_ADC_W-1:0] v);
      adcWord = {{(16-IOSR_ADC_W){1'b0}}, v};
   endfunction

   always_comb begin
      logic [15:0] w;
      w = '0;
      for (int i = 0; i < IOSR_MAX_B; i++) begin
         recBuf[i]  = '0;
         endFlag[i] = 1'b0;
      end
      recBuf[0]  = SAMPLE_SETS;
      endFlag[0] = 1'b1;
      recBuf[1]  = snap.dmask[15:8];
      recBuf[2]  = snap.dmask[7:0];
      endFlag[2] = 1'b1;
      recBuf[3]  = snap.amask;
      endFlag[3] = 1'b1;
      n = IOSR_HDR_B;
      // state bytes only when some line is digital
      if (|snap.dmask) begin
         recBuf[n]      = snap.dstate[15:8];
         recBuf[n+1]    = snap.dstate[7:0];
         endFlag[n+1]   = 1'b1;
         n = n + 2;
      end
      for (int c = 0; c < IOSR_ADC_CH; c++) begin
         if (snap.amask[c]) begin
            w            = adcWord(snap.adc[c]);
            recBuf[n]    = w[15:8];
            recBuf[n+1]  = w[7:0];
            endFlag[n+1] = 1'b1;
            n = n + 2;
         end
      end
      if (snap.amask[IOSR_SUP_BIT]) begin
         w            = adcWord(snap.supply);
         recBuf[n]    = w[15:8];
         recBuf[n+1]  = w[7:0];
         endFlag[n+1] = 1'b1;
         n = n + 2;
      end
   end

   assign byteOut  = recBuf[idx];
   assign fieldEnd = endFlag[idx];
   assign lastOut  = (int'(idx) == n - 1);
endmodule

// file: iosr_rec_sink.sv
// host side consumer of the record stream, able to stall at random
`timescale 1ns/100ps
module iosr_rec_sink (
   // clock
   input  wire logic        clk,
   // stall control
   input  wire logic        slow,
   input  wire logic [15:0] jitter,
   // stream handshake
   output logic             recReady
);
   // a slow host drops ready on random cycles, so bytes must stand
   always @(posedge clk) begin
      recReady <= !slow || jitter[0];
   end
endmodule

// file: iosr_sample_reporter.sv
// io sample reporter: triggers, pin config staging, record sequencing
`timescale 1ns/100ps
module iosr_sample_reporter import iosr_pkg::*; #(
   parameter int MS_CYC = MS_CYCLES
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  clkEn,
   // configuration
   input  iosr_cfg_t                  pinCfgNew,
   input  wire logic                  supplyEnNew,
   input  wire logic                  applyChangesCmd,
   input  wire logic [IOSR_TIME_W-1:0] periodicSampleInterval,
   input  wire logic [IOSR_MASK_W-1:0] changeWatchMask,
   input  wire logic [31:0]           destAddrHigh,
   input  wire logic [31:0]           destAddrLow,
   input  wire logic                  apiMode,
   // sleep control
   input  wire logic                  endDevice,
   input  wire logic                  awake,
   input  wire logic [IOSR_TIME_W-1:0] wakeHoldTimer,
   output logic                       sleepOk,
   // io lines and converter
   input  wire logic [IOSR_LINES-1:0] ioLinesIn,
   input  wire logic [IOSR_ADC_CH-1:0][IOSR_ADC_W-1:0] adcIn,
   input  wire logic [IOSR_ADC_W-1:0] supplyIn,
   // queries
   input  wire logic                  forceSampleQuery,
   input  wire logic                  remoteQuery,
   input  wire logic [63:0]           remoteAddr,
   // received remote samples
   input  wire logic                  rxSampleIn,
   output logic                       rxFwd,
   // record stream
   output logic                       recValid,
   input  wire logic                  recReady,
   output logic [7:0]                 recData,
   output logic                       recLast,
   output logic                       recFieldEnd,
   output iosr_dest_s                 recDest
);
   localparam int MSW = $clog2(MS_CYC + 1);

   typedef enum logic {IOSR_IDLE, IOSR_SEND} iosr_state_e;

   function automatic logic [15:0] digMask(input iosr_cfg_t c);
      digMask = '0;
      for (int i = 0; i < IOSR_LINES; i++) begin
         digMask[i] = (c[i] == CFG_DIN_PLAIN) || (c[i] == CFG_DIN_MON)
                      || (c[i] == CFG_DOUT_LO) || (c[i] == CFG_DOUT_HI);
      end
      digMask = digMask & ~UNUSED_LINES;
   endfunction

   function automatic logic [7:0] anaMask(input iosr_cfg_t c, input logic sup);
      anaMask = '0;
      for (int i = 0; i < IOSR_ADC_CH; i++) begin
         anaMask[i] = (c[i] == CFG_ANALOG);
      end
      anaMask[IOSR_SUP_BIT] = sup;
   endfunction

   // input group: pin sync, staged config
   logic [IOSR_LINES-1:0] ioSync1, ioSync2, ioPrev;
   logic [IOSR_LINES-1:0] next_ioSync1, next_ioSync2, next_ioPrev;
   logic                  primed, next_primed;
   iosr_cfg_t             cfgAct, next_cfgAct;
   logic                  supAct, next_supAct;
   logic [15:0]           dmaskAct, watchAct;
   logic [7:0]            amaskAct;
   logic                  chgFire;

   always_comb begin
      next_ioSync1 = ioLinesIn;
      next_ioSync2 = ioSync1;
      next_ioPrev  = ioSync2;
      next_primed  = 1'b1;
      next_cfgAct  = applyChangesCmd ? pinCfgNew : cfgAct;
      next_supAct  = applyChangesCmd ? supplyEnNew : supAct;
   end

   always_ff @(posedge clk) begin
      if (clkEn) begin // chain runs through reset so release shows no false edge
         ioSync1 <= next_ioSync1;
         ioSync2 <= next_ioSync2;
         ioPrev  <= next_ioPrev;
      end
      if (!nrst) begin
         primed  <= 1'b0;
         cfgAct  <= '0;
         supAct  <= 1'b0;
      end else if (clkEn) begin
         primed  <= next_primed;
         cfgAct  <= next_cfgAct;
         supAct  <= next_supAct;
      end
   end

   assign dmaskAct = digMask(cfgAct);
   assign amaskAct = anaMask(cfgAct, supAct);
   assign watchAct = changeWatchMask & dmaskAct;
   // first cycle after reset has no valid previous state to compare
   assign chgFire  = primed && |(16'(ioSync2 ^ ioPrev) & watchAct);

   // timer group: ms tick, periodic interval, wake hold
   logic [MSW-1:0]         msCnt, next_msCnt;
   logic [IOSR_TIME_W-1:0] irCnt, next_irCnt, wakeCnt, next_wakeCnt;
   logic                   wakeExp, next_wakeExp, awakePrev, next_awakePrev;
   logic                   msTick, perAllowed, perFire;

   assign msTick     = (msCnt == MSW'(MS_CYC - 1));
   assign perAllowed = !endDevice || (awake && !wakeExp);
   assign perFire    = msTick && perAllowed && (periodicSampleInterval != '0)
                       && (irCnt + 16'h0001 >= periodicSampleInterval);

   always_comb begin
      next_msCnt     = msTick ? '0 : msCnt + MSW'(1);
      next_irCnt     = irCnt;
      next_wakeCnt   = wakeCnt;
      next_wakeExp   = wakeExp;
      next_awakePrev = awake;
      if (periodicSampleInterval == '0 || !perAllowed) begin
         next_irCnt = '0;
      end else if (msTick) begin
         next_irCnt = perFire ? '0 : irCnt + 16'h0001;
      end
      if (awake && !awakePrev) begin
         next_wakeCnt = '0;
         next_wakeExp = 1'b0;
      end else if (msTick && awake && !wakeExp) begin
         next_wakeCnt = wakeCnt + 16'h0001;
         next_wakeExp = (wakeCnt + 16'h0001 >= wakeHoldTimer);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         msCnt     <= '0;
         irCnt     <= '0;
         wakeCnt   <= '0;
         wakeExp   <= 1'b0;
         awakePrev <= 1'b0;
      end else if (clkEn) begin
         msCnt     <= next_msCnt;
         irCnt     <= next_irCnt;
         wakeCnt   <= next_wakeCnt;
         wakeExp   <= next_wakeExp;
         awakePrev <= next_awakePrev;
      end
   end

   // record group: pending triggers, snapshot, byte sequencing
   iosr_state_e            state, next_state;
   logic                   pendLocal, pendRemote, pendChg, pendPer;
   logic                   next_pendLocal, next_pendRemote, next_pendChg, next_pendPer;
   logic [63:0]            askAddr, next_askAddr;
   iosr_snap_s             snap, next_snap;
   iosr_dest_s             next_recDest;
   logic [IOSR_IDX_W-1:0]  recIdx, next_recIdx;
   logic                   next_recValid, next_recLast, next_recFieldEnd;
   logic [7:0]             next_recData;
   logic                   next_rxFwd, next_sleepOk;
   logic [7:0]             bByte;
   logic                   bLast, bEnd;
   logic                   takeLocal, takeRemote, takeChg, takePer, start;
   logic [63:0]            destWords;

   iosr_rec_builder u_builder (
      .snap     (snap),
      .idx      (recIdx),
      .byteOut  (bByte),
      .lastOut  (bLast),
      .fieldEnd (bEnd)
   );

   assign destWords  = {destAddrHigh, destAddrLow};
   assign start      = (state == IOSR_IDLE)
                       && (pendLocal || pendRemote || pendChg || pendPer);
   // fixed priority: local query, remote query, change, periodic
   assign takeLocal  = start && pendLocal;
   assign takeRemote = start && !pendLocal && pendRemote;
   assign takeChg    = start && !pendLocal && !pendRemote && pendChg;
   assign takePer    = start && !pendLocal && !pendRemote && !pendChg;

   always_comb begin
      next_state       = state;
      // a new event in the taking cycle survives the clear
      next_pendLocal   = (pendLocal && !takeLocal) || forceSampleQuery;
      next_pendRemote  = (pendRemote && !takeRemote) || remoteQuery;
      next_pendChg     = (pendChg && !takeChg) || chgFire;
      next_pendPer     = (pendPer && !takePer) || perFire;
      next_askAddr     = remoteQuery ? remoteAddr : askAddr;
      next_snap        = snap;
      next_recDest     = recDest;
      next_recIdx      = recIdx;
      next_recValid    = recValid;
      next_recData     = recData;
      next_recLast     = recLast;
      next_recFieldEnd = recFieldEnd;
      next_rxFwd       = rxSampleIn && apiMode;
      next_sleepOk     = endDevice && wakeExp;
      unique case (state)
         IOSR_IDLE: begin
            if (start) begin
               // all channels caught in one cycle
               next_snap.dmask  = dmaskAct;
               next_snap.amask  = amaskAct;
               next_snap.dstate = 16'(ioSync2) & dmaskAct;
               next_snap.adc    = adcIn;
               next_snap.supply = supplyIn;
               next_recDest.framed = apiMode;
               if (takeLocal) begin
                  next_recDest.route   = IOSR_TO_SERIAL;
                  next_recDest.addr    = COORD_ADDR;
                  next_recDest.toCoord = 1'b0;
               end else if (takeRemote) begin
                  next_recDest.route   = IOSR_TO_AIR;
                  next_recDest.addr    = askAddr;
                  next_recDest.toCoord = 1'b0;
               end else begin
                  next_recDest.route   = IOSR_TO_AIR;
                  next_recDest.addr    = destWords;
                  next_recDest.toCoord = (destWords == COORD_ADDR);
               end
               next_recIdx = '0;
               next_state  = IOSR_SEND;
            end
         end
         IOSR_SEND: begin
            if (!recValid) begin
               next_recValid    = 1'b1;
               next_recData     = bByte;
               next_recLast     = bLast;
               next_recFieldEnd = bEnd;
            end else if (recReady) begin
               next_recValid = 1'b0;
               if (recLast) begin
                  next_state = IOSR_IDLE;
               end else begin
                  next_recIdx = recIdx + IOSR_IDX_W'(1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state       <= IOSR_IDLE;
         pendLocal   <= 1'b0;
         pendRemote  <= 1'b0;
         pendChg     <= 1'b0;
         pendPer     <= 1'b0;
         askAddr     <= '0;
         snap        <= '0;
         recDest     <= '0;
         recIdx      <= '0;
         recValid    <= 1'b0;
         recData     <= '0;
         recLast     <= 1'b0;
         recFieldEnd <= 1'b0;
         rxFwd       <= 1'b0;
         sleepOk     <= 1'b0;
      end else if (clkEn) begin
         state       <= next_state;
         pendLocal   <= next_pendLocal;
         pendRemote  <= next_pendRemote;
         pendChg     <= next_pendChg;
         pendPer     <= next_pendPer;
         askAddr     <= next_askAddr;
         snap        <= next_snap;
         recDest     <= next_recDest;
         recIdx      <= next_recIdx;
         recValid    <= next_recValid;
         recData     <= next_recData;
         recLast     <= next_recLast;
         recFieldEnd <= next_recFieldEnd;
         rxFwd       <= next_rxFwd;
         sleepOk     <= next_sleepOk;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence localTaken;
      clkEn && takeLocal;
   endsequence
   sequence remoteTaken;
      clkEn && takeRemote;
   endsequence

   first_byte_a: assert property (recValid && recIdx == '0 |-> recData == SAMPLE_SETS)
      else $error("first record byte is not the sample set count");
   mask_unused_a: assert property (state == IOSR_SEND |->
         snap.dmask[9:8] == 2'b00 && snap.amask[6:4] == 3'b000)
      else $error("unused mask bits set in record");
   local_route_a: assert property (localTaken |=> recDest.route == IOSR_TO_SERIAL)
      else $error("local query not routed to serial port");
   remote_route_a: assert property (remoteTaken |=>
         recDest.route == IOSR_TO_AIR && recDest.addr == $past(askAddr))
      else $error("remote query not answered to asker");
   per_off_a: assert property (periodicSampleInterval == '0 |-> !perFire)
      else $error("periodic sample with interval zero");
   coord_dest_a: assert property (clkEn && (takeChg || takePer) |=>
         recDest.toCoord == (recDest.addr == COORD_ADDR))
      else $error("coordinator flag does not match destination");
   rx_drop_a: assert property (clkEn && rxSampleIn |=> rxFwd == $past(apiMode))
      else $error("received sample forwarding wrong for mode");
   sleep_per_a: assert property (endDevice && wakeExp |-> !perFire)
      else $error("periodic sample after wake timer expired");
   chg_line_a: assert property (chgFire |-> |(16'(ioSync2 ^ ioPrev) & dmaskAct))
      else $error("change trigger from a non-digital line");
   cfg_hold_a: assert property (clkEn && !applyChangesCmd |=> $stable(cfgAct))
      else $error("pin configuration changed without apply");
   chg_pend_a: assert property (clkEn && chgFire |=> pendChg || state == IOSR_SEND)
      else $error("line change lost");
endmodule

// file: iosr_sample_reporter_tb.sv
// self-checking bench for the io sample reporter
`timescale 1ns/100ps
module iosr_sample_reporter_tb import iosr_pkg::*;;
   localparam int MSC = 8;
   logic clk, nrst, clkEn, supplyEnNew, applyChangesCmd, apiMode, endDevice, awake;
   logic sleepOk, forceSampleQuery, remoteQuery, rxSampleIn, rxFwd;
   logic recValid, recReady, recLast, recFieldEnd, slow, actSup, first;
   iosr_cfg_t   pinCfgNew, actCfg;
   logic [15:0] periodicSampleInterval, changeWatchMask, wakeHoldTimer, rnd;
   logic [31:0] destAddrHigh, destAddrLow;
   logic [12:0] ioLinesIn;
   logic [3:0][9:0] adcIn;
   logic [9:0]  supplyIn;
   logic [63:0] remoteAddr, ra;
   logic [7:0]  recData;
   iosr_dest_s  recDest;
   logic [9:0]  gotQ[$];
   iosr_dest_s  dq[$];
   int          errTotal, samplesChecked;

   iosr_sample_reporter #(.MS_CYC(MSC)) iosr_sample_reporter_i (.clk(clk), .nrst(nrst),
      .clkEn(clkEn), .pinCfgNew(pinCfgNew), .supplyEnNew(supplyEnNew),
      .applyChangesCmd(applyChangesCmd), .periodicSampleInterval(periodicSampleInterval),
      .changeWatchMask(changeWatchMask), .destAddrHigh(destAddrHigh),
      .destAddrLow(destAddrLow), .apiMode(apiMode), .endDevice(endDevice), .awake(awake),
      .wakeHoldTimer(wakeHoldTimer), .sleepOk(sleepOk), .ioLinesIn(ioLinesIn),
      .adcIn(adcIn), .supplyIn(supplyIn), .forceSampleQuery(forceSampleQuery),
      .remoteQuery(remoteQuery), .remoteAddr(remoteAddr), .rxSampleIn(rxSampleIn),
      .rxFwd(rxFwd), .recValid(recValid), .recReady(recReady), .recData(recData),
      .recLast(recLast), .recFieldEnd(recFieldEnd), .recDest(recDest));
   iosr_rec_sink iosr_rec_sink_i (.clk(clk), .slow(slow), .jitter(rnd), .recReady(recReady));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // expected record as {last, field end, byte} words
   function automatic void build(output logic [9:0] q[$]);
      logic [15:0] dm, ws[$];
      logic [7:0]  am;
      q = {};
      dm = 16'h0;
      am = {7'h0, 1'b0};
      for (int i = 0; i < IOSR_LINES; i++) begin
         if (i != 8 && i != 9 && actCfg[i] inside {4'h0, 4'h3, 4'h4, 4'h5}) dm[i] = 1'b1;
         if (i < IOSR_ADC_CH && actCfg[i] == CFG_ANALOG) am[i] = 1'b1;
      end
      am[IOSR_SUP_BIT] = actSup;
      if (dm != 16'h0) ws.push_back({3'h0, ioLinesIn} & dm);
      for (int c = 0; c < IOSR_ADC_CH; c++) if (am[c]) ws.push_back({6'h0, adcIn[c]});
      if (actSup) ws.push_back({6'h0, supplyIn});
      q.push_back({2'h1, SAMPLE_SETS});
      q.push_back({2'h0, dm[15:8]});
      q.push_back({2'h1, dm[7:0]});
      q.push_back({2'h1, am});
      foreach (ws[i]) begin
         q.push_back({2'h0, ws[i][15:8]});
         q.push_back({2'h1, ws[i][7:0]});
      end
      q[q.size()-1][9] = 1'b1;
   endfunction

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic flush();
      gotQ.delete();
      dq.delete();
      first = 1'b1;
   endtask

   // waits for one whole record and compares bytes and destination
   task automatic get_rec(input logic air, input logic crd, input logic [63:0] ad);
      logic [9:0] eq[$];
      int n;
      n = 0;
      while ((gotQ.size() == 0 || gotQ[$][9] !== 1'b1) && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      // inputs stand still during a record, so expect from them afterwards
      build(eq);
      chk("length", eq.size(), gotQ.size());
      for (int i = 0; i < eq.size(); i++)
         chk("byte", eq[i], i < gotQ.size() ? gotQ[i] : 10'h3ff);
      if (dq.size() > 0) begin
         chk("route", air, dq[0].route);
         chk("coord", crd, dq[0].toCoord);
         chk("framed", apiMode, dq[0].framed);
         chk("addr", ad, dq[0].addr);
      end
      flush();
      @(posedge clk);
   endtask

   task automatic apply_cfg(input iosr_cfg_t c, input logic s);
      @(posedge clk);
      pinCfgNew <= c;
      supplyEnNew <= s;
      applyChangesCmd <= 1'b1;
      @(posedge clk);
      applyChangesCmd <= 1'b0;
      actCfg = c;
      actSup = s;
      tick(4);
   endtask

   task automatic query(input logic rem);
      @(posedge clk);
      ra = {rnd, 16'h5a3c, ~rnd, 16'h0f21};
      remoteAddr <= ra;
      remoteQuery <= rem;
      forceSampleQuery <= !rem;
      @(posedge clk);
      remoteQuery <= 1'b0;
      forceSampleQuery <= 1'b0;
   endtask

   // random pin configs, pin levels and converter readings
   task automatic stir(output iosr_cfg_t c);
      logic [15:0] s;
      s = rnd;
      for (int i = 0; i < IOSR_LINES; i++) begin
         s = lfsr(s);
         c[i] = 4'(s % 16'h6);
      end
      @(posedge clk);
      ioLinesIn <= s[12:0];
      for (int i = 0; i < IOSR_ADC_CH; i++) begin
         s = lfsr(s);
         adcIn[i] <= s[9:0];
      end
      supplyIn <= s[15:6];
      apiMode <= s[3];
      slow <= s[5];
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      if (nrst && recValid && recReady) begin
         if (first) dq.push_back(recDest);
         gotQ.push_back({recLast, recFieldEnd, recData});
         first = recLast;
      end
   end

   initial begin
      repeat (60000) @(posedge clk);
      errTotal++;
      $display("watchdog expired");
      conclude();
   end

   initial begin
      iosr_cfg_t c;
      logic [63:0] da;
      int n;
      {nrst, supplyEnNew, applyChangesCmd, apiMode, endDevice, awake} = 6'h0;
      {forceSampleQuery, remoteQuery, rxSampleIn, slow, actSup} = 5'h0;
      clkEn = 1'b1;
      pinCfgNew = '0;
      actCfg = '0;
      {periodicSampleInterval, changeWatchMask, wakeHoldTimer} = 48'h0;
      {destAddrHigh, destAddrLow, remoteAddr, ra} = '0;
      ioLinesIn = 13'h0;
      adcIn = '0;
      supplyIn = 10'h0;
      rnd = 16'h0050;
      first = 1'b1;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick(2);
      // no digital lines, converter at both ends of its range
      c = {IOSR_LINES{4'h1}};
      c[0] = CFG_ANALOG;
      c[3] = CFG_ANALOG;
      adcIn <= {ADC_FULL, 10'h155, 10'h2aa, 10'h000};
      supplyIn <= ADC_FULL;
      apply_cfg(c, 1'b1);
      query(1'b0);
      get_rec(IOSR_TO_SERIAL, 1'b0, 64'h0);
      $display("test analog only done");
      for (int k = 0; k < 10; k++) begin
         stir(c);
         apply_cfg(c, k[1]);
         query(k[0]);
         get_rec(k[0], 1'b0, k[0] ? ra : 64'h0);
      end
      $display("test random queries done");
      @(posedge clk);
      pinCfgNew <= {IOSR_LINES{CFG_DIN_MON}};
      supplyEnNew <= !actSup;
      tick(4);
      query(1'b0);
      get_rec(IOSR_TO_SERIAL, 1'b0, 64'h0);
      $display("test staged config done");
      slow <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         da = k ? {16'h0a5c, rnd, 16'h1357, rnd} : 64'h0;
         {destAddrHigh, destAddrLow} <= da;
         periodicSampleInterval <= 16'h3;
         get_rec(IOSR_TO_AIR, da == 64'h0, da);
         periodicSampleInterval <= 16'h0;
         tick(40);
         flush();
      end
      tick(100);
      chk("interval off", 0, gotQ.size());
      $display("test periodic done");
      endDevice <= 1'b1;
      periodicSampleInterval <= 16'h1;
      tick(60);
      chk("asleep", 0, gotQ.size());
      awake <= 1'b1;
      wakeHoldTimer <= 16'h3;
      get_rec(IOSR_TO_AIR, 1'b0, da);
      n = 0;
      while (sleepOk !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("sleep ok", 1, sleepOk);
      tick(80);
      flush();
      tick(60);
      chk("after wake", 0, gotQ.size());
      {endDevice, awake} <= 2'h0;
      periodicSampleInterval <= 16'h0;
      $display("test sleep done");
      c = {IOSR_LINES{4'h1}};
      c[0] = CFG_ANALOG;
      c[5] = CFG_DIN_MON;
      apply_cfg(c, 1'b0);
      changeWatchMask <= 16'h0021;
      tick(10);
      flush();
      ioLinesIn[0] <= !ioLinesIn[0];
      tick(40);
      chk("analog line", 0, gotQ.size());
      ioLinesIn[5] <= !ioLinesIn[5];
      get_rec(IOSR_TO_AIR, 1'b0, da);
      changeWatchMask <= 16'h0;
      $display("test change done");
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         apiMode <= m[0];
         rxSampleIn <= 1'b1;
         @(posedge clk);
         rxSampleIn <= 1'b0;
         #1;
         chk("forward", m, rxFwd);
         @(posedge clk);
         #1;
         chk("forward end", 0, rxFwd);
      end
      // a frozen block must not take the arrival
      @(posedge clk);
      clkEn <= 1'b0;
      rxSampleIn <= 1'b1;
      @(posedge clk);
      rxSampleIn <= 1'b0;
      #1;
      chk("frozen forward", 0, rxFwd);
      @(posedge clk);
      clkEn <= 1'b1;
      $display("test forward done");
      conclude();
   end
endmodule
